// ==== design/seq_table.sv ====
// Contract
// R01 - table holds 16777215 entries of six words
// R02 - reads only stopped; writes also dynamic running
// R03 - read errors if write-only segment exists
// R04 - reset command returns entries to defaults
// R05 - fixed word order for data/idle entries
// R06 - host writes zero to reserved fields
// R07 - control bit 31 selects data or command
// R08 - control bit 28 marks sequence start
// R09 - bit 30 ends sequence, 29 ends scenario
// R10 - bit 24 marker enable, data only
// R11 - bits 23:20 sequence advancement mode
// R12 - bits 19:16 segment advancement mode, data
// R13 - sequence loop used from first entry
// R14 - segment loop count is 32 bits
// R15 - segment id bits 24:0
// R16 - host keeps start offset granular
// R17 - end offset all ones means last
// R18 - command code bits 15:0, zero idle
// R19 - idle outputs 8-bit sample bits 7:0
// R20 - idle delay minimum per rate divider
// R21 - extended channels share one table
// R22 - transfer may span several entries
// R23 - dynamic mode allows switching while running
// R24 - consecutive six-word groups, consecutive indices
module seq_table
    import seq_table_pkg::*;
#(
    parameter int DEPTH = TABLE_ENTRIES,
    parameter int IDX_W = 24
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // register bus
    input wire apb_req_t apb_req,
    output apb_rsp_t apb_rsp,
    // waveform memory status
    input wire logic wo_segment,
    input wire logic [1:0] sr_div,
    // entry fetch from the sequencer
    input wire logic dec_req,
    input wire logic [IDX_W-1:0] dec_index,
    output logic dec_valid,
    output entry_t dec_entry,
    // generation control
    output logic gen_run,
    output logic gen_dynamic,
    output logic [IDX_W-1:0] next_entry
);

    // ----------------------------------------
    // storage and state
    // ----------------------------------------
    localparam int TOTAL_WORDS = DEPTH * ENTRY_WORDS;
    localparam int AW = $clog2(TOTAL_WORDS);
    localparam logic [AW-1:0] LAST_WORD = AW'(TOTAL_WORDS - 1);

    typedef struct packed {
        tbl_state_t st;
        logic run;
        logic dyn;
        logic rd_err;
        logic wr_err;
        logic [IDX_W-1:0] idx;
        logic [2:0] word;
        logic [IDX_W-1:0] next_idx;
        logic [AW-1:0] clr;
        apb_rsp_t rsp;
        logic dec_valid;
        entry_t ent;
    } state_t;

    state_t s_q;
    state_t s_d;
    logic [31:0] mem [TOTAL_WORDS]; // R01
    logic mem_we;
    logic [AW-1:0] mem_wa;
    logic [31:0] mem_wd;
    logic rd_ok;
    logic wr_ok;
    logic setup;
    logic access;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // word address of one word of one entry
    function automatic logic [AW-1:0] word_addr(input logic [IDX_W-1:0] i,
                                                input logic [2:0] w);
        word_addr = AW'(i * ENTRY_WORDS + w); // R01 R05
    endfunction

    // least idle delay for the current rate divider
    function automatic logic [31:0] min_idle(input logic [1:0] div);
        case (div)
            2'h0: min_idle = 32'(IDLE_MIN_UNITS * IDLE_GRAN_DIV1); // R20
            2'h1: min_idle = 32'(IDLE_MIN_UNITS * IDLE_GRAN_DIV2); // R20
            default: min_idle = 32'(IDLE_MIN_UNITS * IDLE_GRAN_DIV4); // R20
        endcase
    endfunction

    // split six words of one entry into its fields
    function automatic entry_t decode(input logic [31:0] w0, input logic [31:0] w1,
                                      input logic [31:0] w2, input logic [31:0] w3,
                                      input logic [31:0] w4, input logic [31:0] w5,
                                      input logic [1:0] div);
        entry_t e;
        e = '0;
        e.is_cmd = w0[CTL_CMD_BIT]; // R07
        e.end_seq = w0[CTL_END_SEQ_BIT]; // R09
        e.end_scen = w0[CTL_END_SCEN_BIT]; // R09
        e.init_seq = w0[CTL_INIT_SEQ_BIT]; // R08
        e.seq_adv = w0[SEQ_ADV_LSB+:4]; // R11
        e.adv_bad = w0[SEQ_ADV_LSB+:4] > ADV_SINGLE; // R11
        e.seq_loop = e.init_seq ? w1 : 32'h0; // R13
        if (!e.is_cmd) begin
            e.marker_en = w0[CTL_MARKER_BIT]; // R10
            e.seg_adv = w0[SEG_ADV_LSB+:4]; // R12
            e.adv_bad = e.adv_bad || (w0[SEG_ADV_LSB+:4] > ADV_SINGLE); // R12
            e.seg_loop = w2; // R14
            e.seg_id = w3[SEG_ID_W-1:0]; // R15
            e.start_ofs = w4;
            e.end_ofs = w5;
            e.end_last = (w5 == END_IS_LAST); // R17
        end else begin
            e.cmd_code = w2[CMD_CODE_W-1:0]; // R18
            e.is_idle = (w2[CMD_CODE_W-1:0] == CMD_IDLE_DELAY); // R18
            e.idle_sample = w3[IDLE_SAMPLE_W-1:0]; // R19
            e.idle_delay = w4;
            e.delay_short = e.is_idle && (w4 < min_idle(div)); // R20
        end
        decode = e;
    endfunction

    // ----------------------------------------
    // next-state logic
    // ----------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.dec_valid = 1'b0;
        mem_we = 1'b0;
        mem_wa = '0;
        mem_wd = 32'h0;
        rd_ok = !s_q.run && !wo_segment && (s_q.st == ST_READY); // R02 R03
        wr_ok = (!s_q.run || s_q.dyn) && (s_q.st == ST_READY); // R02 R23
        setup = apb_req.psel && !apb_req.penable;
        access = apb_req.psel && apb_req.penable && s_q.rsp.pready;

        // setup cycle: prepare answer, ready in access phase
        if (setup) begin
            s_d.rsp.pready = 1'b1;
            s_d.rsp.pslverr = 1'b0;
            s_d.rsp.prdata = 32'h0;
            case (apb_req.paddr)
                REG_CTRL: begin
                    s_d.rsp.prdata[CTRL_RUN_BIT] = s_q.run;
                    s_d.rsp.prdata[CTRL_DYN_BIT] = s_q.dyn;
                end
                REG_STATUS: begin
                    s_d.rsp.prdata[ST_BUSY_BIT] = (s_q.st == ST_CLEAR);
                    s_d.rsp.prdata[ST_RD_ERR_BIT] = s_q.rd_err;
                    s_d.rsp.prdata[ST_WR_ERR_BIT] = s_q.wr_err;
                end
                REG_INDEX: s_d.rsp.prdata[IDX_W-1:0] = s_q.idx;
                REG_WORD: s_d.rsp.prdata[2:0] = s_q.word;
                REG_DATA: begin
                    if (apb_req.pwrite) begin
                        s_d.rsp.pslverr = !wr_ok; // R02
                    end else if (rd_ok) begin
                        s_d.rsp.prdata = mem[word_addr(s_q.idx, s_q.word)];
                    end else begin
                        s_d.rsp.pslverr = 1'b1; // R02 R03
                    end
                end
                REG_CMD: s_d.rsp.pslverr = apb_req.pwrite && !wr_ok;
                REG_NEXT: begin
                    s_d.rsp.prdata[IDX_W-1:0] = s_q.next_idx;
                    s_d.rsp.pslverr = apb_req.pwrite && s_q.run && !s_q.dyn; // R23
                end
                default: s_d.rsp.pslverr = 1'b1;
            endcase
        end else if (access) begin
            // access phase: commit at the ready edge
            s_d.rsp.pready = 1'b0;
            if (s_q.rsp.pslverr) begin
                if (apb_req.paddr == REG_DATA && apb_req.pwrite) begin
                    s_d.wr_err = 1'b1;
                end else if (apb_req.paddr == REG_DATA) begin
                    s_d.rd_err = 1'b1;
                end
            end else begin
                case (apb_req.paddr)
                    REG_CTRL: begin
                        if (apb_req.pwrite) begin
                            s_d.run = apb_req.pwdata[CTRL_RUN_BIT];
                            s_d.dyn = apb_req.pwdata[CTRL_DYN_BIT];
                        end
                    end
                    REG_STATUS: begin
                        if (apb_req.pwrite) begin
                            s_d.rd_err = s_q.rd_err && !apb_req.pwdata[ST_RD_ERR_BIT];
                            s_d.wr_err = s_q.wr_err && !apb_req.pwdata[ST_WR_ERR_BIT];
                        end
                    end
                    REG_INDEX: begin
                        if (apb_req.pwrite) begin
                            s_d.idx = apb_req.pwdata[IDX_W-1:0]; // R22
                            s_d.word = W_CTRL;
                        end
                    end
                    REG_WORD: begin
                        if (apb_req.pwrite && apb_req.pwdata[2:0] <= W_END) begin
                            s_d.word = apb_req.pwdata[2:0];
                        end
                    end
                    REG_DATA: begin
                        if (apb_req.pwrite) begin
                            mem_we = 1'b1;
                            mem_wa = word_addr(s_q.idx, s_q.word); // R05
                            mem_wd = apb_req.pwdata;
                        end
                        // step through words, then on to the next entry
                        if (s_q.word == W_END) begin
                            s_d.word = W_CTRL;
                            s_d.idx = s_q.idx + IDX_W'(1); // R22 R24
                        end else begin
                            s_d.word = s_q.word + 3'h1;
                        end
                    end
                    REG_CMD: begin
                        if (apb_req.pwrite && apb_req.pwdata[CMD_RESET_BIT]) begin
                            s_d.st = ST_CLEAR; // R04
                            s_d.clr = '0;
                        end
                    end
                    REG_NEXT: begin
                        if (apb_req.pwrite) begin
                            s_d.next_idx = apb_req.pwdata[IDX_W-1:0]; // R23
                        end
                    end
                    default: s_d.rsp.pslverr = 1'b0;
                endcase
            end
        end else begin
            s_d.rsp.pready = 1'b0;
        end

        // table reset sweep, one word per cycle
        case (s_q.st)
            ST_READY: s_d.clr = s_d.clr;
            ST_CLEAR: begin
                mem_we = 1'b1;
                mem_wa = s_q.clr;
                mem_wd = ENTRY_DEFAULT; // R04
                if (s_q.clr == LAST_WORD) begin
                    s_d.st = ST_READY;
                end else begin
                    s_d.clr = s_q.clr + AW'(1);
                end
            end
            default: s_d.st = ST_READY;
        endcase

        // entry fetch; one decoded entry feeds every extended channel
        if (dec_req && s_q.st == ST_READY) begin
            s_d.dec_valid = 1'b1;
            s_d.ent = decode(mem[word_addr(dec_index, W_CTRL)], // R21
                             mem[word_addr(dec_index, W_SEQ_LOOP)],
                             mem[word_addr(dec_index, W_SEG_LOOP)],
                             mem[word_addr(dec_index, W_SEG_ID)],
                             mem[word_addr(dec_index, W_START)],
                             mem[word_addr(dec_index, W_END)],
                             sr_div);
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    // state register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_q <= '0;
            s_q.st <= ST_READY;
        end else begin
            s_q <= s_d;
        end
    end

    // table memory write port, contents survive sys_rst
    always_ff @(posedge clk) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    // outputs
    assign apb_rsp = s_q.rsp;
    assign dec_valid = s_q.dec_valid;
    assign dec_entry = s_q.ent;
    assign gen_run = s_q.run;
    assign gen_dynamic = s_q.dyn;
    assign next_entry = s_q.next_idx;

endmodule

// ==== design/seq_table_pkg.sv ====
package seq_table_pkg;

    // ----------------------------------------
    // table geometry
    // ----------------------------------------
    localparam int TABLE_ENTRIES = 16777215;
    localparam int ENTRY_WORDS = 6;
    localparam logic [2:0] W_CTRL = 3'h0;
    localparam logic [2:0] W_SEQ_LOOP = 3'h1;
    localparam logic [2:0] W_SEG_LOOP = 3'h2; // command code on idle entries
    localparam logic [2:0] W_SEG_ID = 3'h3; // idle sample on idle entries
    localparam logic [2:0] W_START = 3'h4; // idle delay on idle entries
    localparam logic [2:0] W_END = 3'h5; // zero on idle entries
    localparam logic [31:0] ENTRY_DEFAULT = 32'h0;

    // ----------------------------------------
    // control word fields
    // ----------------------------------------
    localparam int CTL_CMD_BIT = 31;
    localparam int CTL_END_SEQ_BIT = 30;
    localparam int CTL_END_SCEN_BIT = 29;
    localparam int CTL_INIT_SEQ_BIT = 28;
    localparam int CTL_MARKER_BIT = 24;
    localparam int SEQ_ADV_LSB = 20;
    localparam int SEG_ADV_LSB = 16;
    localparam int SEG_ID_W = 25;
    localparam int CMD_CODE_W = 16;
    localparam int IDLE_SAMPLE_W = 8;
    localparam logic [15:0] CMD_IDLE_DELAY = 16'h0000;
    localparam logic [31:0] END_IS_LAST = 32'hffffffff;
    localparam int IDLE_MIN_UNITS = 10;
    localparam int IDLE_GRAN_DIV1 = 256;
    localparam int IDLE_GRAN_DIV2 = 128;
    localparam int IDLE_GRAN_DIV4 = 64;

    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_INDEX = 8'h08;
    localparam logic [7:0] REG_WORD = 8'h0c;
    localparam logic [7:0] REG_DATA = 8'h10;
    localparam logic [7:0] REG_CMD = 8'h14;
    localparam logic [7:0] REG_NEXT = 8'h18;
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_DYN_BIT = 1;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_RD_ERR_BIT = 1;
    localparam int ST_WR_ERR_BIT = 2;
    localparam int CMD_RESET_BIT = 0;

    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [3:0] {
        ADV_AUTO = 4'h0,
        ADV_COND = 4'h1,
        ADV_REPEAT = 4'h2,
        ADV_SINGLE = 4'h3
    } adv_mode_t;

    typedef enum logic [1:0] {
        ST_READY = 2'b01,
        ST_CLEAR = 2'b10
    } tbl_state_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;

    typedef struct packed {
        logic is_cmd;
        logic is_idle;
        logic end_seq;
        logic end_scen;
        logic init_seq;
        logic marker_en;
        logic [3:0] seq_adv;
        logic [3:0] seg_adv;
        logic adv_bad;
        logic [31:0] seq_loop;
        logic [31:0] seg_loop;
        logic [SEG_ID_W-1:0] seg_id;
        logic [31:0] start_ofs;
        logic [31:0] end_ofs;
        logic end_last;
        logic [CMD_CODE_W-1:0] cmd_code;
        logic [IDLE_SAMPLE_W-1:0] idle_sample;
        logic [31:0] idle_delay;
        logic delay_short;
    } entry_t;

endpackage

// ==== verif/seq_fetch.sv ====
module seq_fetch
    import seq_table_pkg::*;
(
    // clock
    input wire logic clk,
    // fetch port
    output logic dec_req,
    output logic [23:0] dec_index,
    input wire logic dec_valid,
    input wire entry_t dec_entry,
    // playback view
    output logic [7:0] dac_out
);
    timeunit 1ns;
    timeprecision 1ps;
    entry_t got;
    logic ok;

    initial begin
        dec_req = 1'b0;
        dec_index = 24'h0;
        dac_out = 8'h0;
    end

    // one request, then wait a few edges for the decoded entry
    task fetch(input logic [23:0] idx);
        int n;
        @(posedge clk);
        dec_req <= 1'b1;
        dec_index <= idx;
        @(posedge clk);
        dec_req <= 1'b0;
        dec_index <= ~idx; // index is meaningless once released
        ok = 1'b0;
        for (n = 0; n < 4; n++) begin
            @(posedge clk);
            if (dec_valid === 1'b1) begin
                ok = 1'b1;
                got = dec_entry;
                break;
            end
        end
    endtask

    // idle entries hold the programmed sample on the converter
    always @(posedge clk) begin
        if (dec_valid && dec_entry.is_idle) dac_out <= dec_entry.idle_sample;
    end
endmodule

// ==== verif/seq_table_checker.sv ====
module seq_table_checker
    import seq_table_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // register bus
    input wire apb_req_t apb_req,
    input wire apb_rsp_t apb_rsp,
    // memory status and fetch
    input wire logic wo_segment,
    input wire logic [1:0] sr_div,
    input wire logic dec_req,
    input wire logic dec_valid,
    input wire entry_t dec_entry,
    input wire logic gen_run,
    input wire logic gen_dynamic
);
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    // shortest legal idle delay for a rate divider code
    function automatic logic [31:0] min_delay(input logic [1:0] d);
        return (d == 2'h0) ? 32'd2560 : (d == 2'h1) ? 32'd1280 : 32'd640;
    endfunction

    sequence s_rd_setup;
        apb_req.psel && !apb_req.penable && !apb_req.pwrite && apb_req.paddr == REG_DATA;
    endsequence
    sequence s_wr_setup;
        apb_req.psel && !apb_req.penable && apb_req.pwrite && apb_req.paddr == REG_DATA;
    endsequence
    sequence s_refused;
        apb_rsp.pready && apb_rsp.pslverr;
    endsequence

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    a_rd_wo_refused: assert property ((s_rd_setup ##0 wo_segment) |=> s_refused)
        else $error("read allowed with write-only segment");
    a_rd_run_refused: assert property ((s_rd_setup ##0 gen_run) |=> s_refused)
        else $error("read allowed while running");
    a_wr_run_refused: assert property ((s_wr_setup ##0 (gen_run && !gen_dynamic))
        |=> s_refused)
        else $error("write allowed while running static");
    a_valid_cause: assert property (dec_valid |-> $past(dec_req))
        else $error("decode valid without request");
    a_idle_code: assert property (dec_valid |-> dec_entry.is_idle
        == (dec_entry.is_cmd && dec_entry.cmd_code == CMD_IDLE_DELAY))
        else $error("idle flag wrong");
    a_data_only: assert property (dec_valid && dec_entry.is_cmd
        |-> !dec_entry.marker_en && dec_entry.seg_adv == 4'h0 && dec_entry.seg_loop == 32'h0)
        else $error("data field on command entry");
    a_cmd_only: assert property (dec_valid && !dec_entry.is_cmd
        |-> dec_entry.cmd_code == 16'h0 && dec_entry.idle_delay == 32'h0)
        else $error("command field on data entry");
    a_adv_bad: assert property (dec_valid |-> dec_entry.adv_bad
        == (dec_entry.seq_adv > 4'h3 || dec_entry.seg_adv > 4'h3))
        else $error("reserved mode flag wrong");
    a_seq_loop_first: assert property (dec_valid && !dec_entry.init_seq
        |-> dec_entry.seq_loop == 32'h0)
        else $error("loop count outside first entry");
    a_end_last: assert property (dec_valid |-> dec_entry.end_last
        == (dec_entry.end_ofs == END_IS_LAST))
        else $error("end flag wrong");
    a_delay_short: assert property (dec_valid && dec_entry.is_idle
        |-> dec_entry.delay_short == (dec_entry.idle_delay < min_delay($past(sr_div))))
        else $error("short delay flag wrong");
endmodule

bind seq_table seq_table_checker i_chk (.clk(clk), .sys_rst(sys_rst), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .wo_segment(wo_segment), .sr_div(sr_div), .dec_req(dec_req),
    .dec_valid(dec_valid), .dec_entry(dec_entry), .gen_run(gen_run),
    .gen_dynamic(gen_dynamic));

// ==== verif/testbench.sv ====
module testbench
    import seq_table_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, sys_rst, wo_segment, dec_req, dec_valid, gen_run, gen_dynamic, err;
    logic [1:0] sr_div;
    logic [23:0] dec_index, next_entry;
    logic [7:0] dac;
    logic [31:0] rd;
    logic [31:0] tbl [12];
    apb_req_t req;
    apb_rsp_t rsp;
    entry_t dec_entry, ex;
    int errors, n_compared;

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    seq_table #(.DEPTH(16), .IDX_W(24)) i_dut (.clk(clk), .sys_rst(sys_rst), .apb_req(req),
        .apb_rsp(rsp), .wo_segment(wo_segment), .sr_div(sr_div), .dec_req(dec_req),
        .dec_index(dec_index), .dec_valid(dec_valid), .dec_entry(dec_entry),
        .gen_run(gen_run), .gen_dynamic(gen_dynamic), .next_entry(next_entry));
    seq_fetch i_fetch (.clk(clk), .dec_req(dec_req), .dec_index(dec_index),
        .dec_valid(dec_valid), .dec_entry(dec_entry), .dac_out(dac));

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task close_out;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task chk(input string what, input logic [255:0] exp, input logic [255:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one apb transfer, held until pready is sampled high
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge clk);
        req <= '{1'b1, 1'b0, w, a, wd};
        @(posedge clk);
        req.penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (rsp.pready === 1'b1) break;
        end
        if (n == 20) begin
            errors++;
            close_out;
        end
        rd = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
    endtask

    task clear_table;
        int n;
        xfer(1'b1, REG_CMD, 32'h1);
        for (n = 0; n < 200; n++) begin
            xfer(1'b0, REG_STATUS, 32'h0);
            if (rd[ST_BUSY_BIT] === 1'b0) break;
        end
        if (n == 200) begin
            errors++;
            close_out;
        end
    endtask

    task fetch_chk(input logic [23:0] idx, input string what);
        i_fetch.fetch(idx);
        chk("fetch answered", 1'b1, i_fetch.ok);
        chk(what, ex, i_fetch.got);
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        errors = 0;
        n_compared = 0;
        sys_rst = 1'b1;
        req = '0;
        wo_segment = 1'b0;
        sr_div = 2'h0;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        clear_table;
        ex = '0;
        fetch_chk(24'h7, "cleared entry");
        $display("test done: clear");
        // data entry at 2, idle entry at 3, reserved bits zero
        tbl = '{32'h51230000, 1, 2, 3, 240, 32'hffffffff,
            32'ha0000000, 1, 0, 32'ha5, 2559, 0};
        xfer(1'b1, REG_INDEX, 32'h2);
        foreach (tbl[i]) xfer(1'b1, REG_DATA, tbl[i]);
        xfer(1'b1, REG_INDEX, 32'h2);
        foreach (tbl[i]) begin
            xfer(1'b0, REG_DATA, 32'h0);
            chk("read back", tbl[i], rd);
        end
        ex = '0;
        ex.end_seq = 1'b1;
        ex.init_seq = 1'b1;
        ex.marker_en = 1'b1;
        ex.seq_adv = 4'h2;
        ex.seg_adv = 4'h3;
        ex.seq_loop = 32'h1;
        ex.seg_loop = 32'h2;
        ex.seg_id = 25'h3;
        ex.start_ofs = 32'd240;
        ex.end_ofs = 32'hffffffff;
        ex.end_last = 1'b1;
        fetch_chk(24'h2, "data entry");
        ex = '0;
        ex.is_cmd = 1'b1;
        ex.is_idle = 1'b1;
        ex.end_scen = 1'b1;
        ex.idle_sample = 8'ha5;
        ex.idle_delay = 32'd2559;
        ex.delay_short = 1'b1;
        fetch_chk(24'h3, "idle entry div1");
        sr_div <= 2'h1;
        ex.delay_short = 1'b0;
        fetch_chk(24'h3, "idle entry div2");
        chk("idle sample out", 8'ha5, dac);
        // every advancement code, the first reserved one too
        for (int m = 0; m < 5; m++) begin
            xfer(1'b1, REG_INDEX, 32'h4);
            xfer(1'b1, REG_DATA, (m << 20) | (m << 16));
            for (int k = 0; k < 5; k++) xfer(1'b1, REG_DATA, 32'h0);
            ex = '0;
            ex.seq_adv = m[3:0];
            ex.seg_adv = m[3:0];
            ex.adv_bad = (m > 3);
            fetch_chk(24'h4, "advance modes");
        end
        $display("test done: entries");
        wo_segment <= 1'b1;
        xfer(1'b1, REG_INDEX, 32'h2);
        xfer(1'b0, REG_DATA, 32'h0);
        chk("read with write-only segment", 1'b1, err);
        wo_segment <= 1'b0;
        xfer(1'b0, REG_DATA, 32'h0);
        chk("pointer held", tbl[0], rd);
        // word select, an out-of-range word is ignored
        xfer(1'b1, REG_WORD, 32'h3);
        xfer(1'b1, REG_WORD, 32'h7);
        xfer(1'b0, REG_DATA, 32'h0);
        chk("word select", tbl[3], rd);
        xfer(1'b1, REG_CTRL, 32'h1);
        xfer(1'b1, REG_DATA, 32'h0);
        chk("write while running", 1'b1, err);
        xfer(1'b0, REG_DATA, 32'h0);
        chk("read while running", 1'b1, err);
        xfer(1'b1, REG_NEXT, 32'h5);
        chk("switch while static", 1'b1, err);
        xfer(1'b0, REG_STATUS, 32'h0);
        chk("error flags", 32'h6, rd);
        xfer(1'b1, REG_STATUS, 32'h6);
        xfer(1'b1, REG_CTRL, 32'h3);
        xfer(1'b1, REG_NEXT, 32'h5);
        chk("switch while dynamic", 1'b0, err);
        xfer(1'b0, REG_NEXT, 32'h0);
        chk("next readback", 32'h5, rd);
        xfer(1'b0, REG_CTRL, 32'h0);
        chk("ctrl readback", 32'h3, rd);
        xfer(1'b1, REG_INDEX, 32'h3);
        chk("next entry", 24'h5, next_entry);
        chk("run and dynamic", 2'h3, {gen_dynamic, gen_run});
        xfer(1'b1, REG_DATA, 32'h80000000);
        chk("write while dynamic", 1'b0, err);
        xfer(1'b0, 8'h40, 32'h0);
        chk("unmapped address", 1'b1, err);
        $display("test done: access control");
        xfer(1'b1, REG_CTRL, 32'h0);
        clear_table;
        ex = '0;
        fetch_chk(24'h2, "entry after table reset");
        $display("test done: second clear");
        close_out;
    end
endmodule
